// >>> core/current_output_param_diag_bank.sv
// parameter record, output range control and diagnostic record of a two-channel current output
`timescale 1ns/1ps
`include "aout_consts.svh"
module current_output_param_diag_bank
  import aout_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                rec_req,
  input  wire logic                rec_write,
  input  wire access_mode_t        rec_mode,
  input  wire logic [15:0]         object_index,
  input  wire logic [7:0]          object_subindex,
  input  wire logic [4:0]          rec_offset,
  input  wire logic [7:0]          rec_wdata,
  output logic [7:0]               rec_rdata,
  output logic                     rec_ack,
  output logic                     rec_err,
  input  wire logic [1:0][15:0]    out_code,
  input  wire logic [1:0]          wire_break_pin,
  input  wire logic                module_failure,
  input  wire logic                internal_error,
  input  wire logic                aux_supply_missing,
  input  wire logic                diag_overflow,
  input  wire logic                comm_error,
  output logic [1:0][14:0]         current_ua,
  output logic [1:0]               channel_on,
  output logic [1:0]               channel_error_led,
  output logic                     group_error_led
);

  // record_set_number is carried on object_index[7:0] in record mode
  wire logic [7:0]  record_set_number;
  assign record_set_number = object_index[7:0];

  // parameter record, ticker, stamp, wire-break sync and record port storage
  byte_t            wbe_reg;
  byte_t            fn_reg [2];
  logic [31:0]      ticker_reg;
  logic [4:0]       tick_div_reg;
  logic [31:0]      stamp_reg;
  logic [31:0]      diag_prev_reg;
  logic [1:0]       wb_meta_reg;
  logic [1:0]       wb_sync_reg;
  byte_t            rdata_reg;
  logic             ack_reg;
  logic             err_reg;

  // per-channel results
  wire logic [1:0]  fn_bad;
  wire logic [1:0]  fn_off;
  wire logic [1:0]  wb_err;
  byte_t            ch_err_byte [2];

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      wire byte_t               fn;
      wire logic                is_31;
      wire logic                is_41;
      wire logic                is_30;
      wire logic                is_40;
      wire logic                fs16k;
      wire logic                live_zero;
      wire logic signed [15:0]  code;
      wire logic signed [15:0]  hi;
      wire logic signed [15:0]  lo;
      wire logic signed [15:0]  lim;
      wire logic signed [31:0]  prod;
      wire logic signed [31:0]  quot;
      wire logic signed [31:0]  ua;
      logic [14:0]              cur_reg;
      logic                     on_reg;
      assign fn = fn_reg[c];
      assign is_31 = (fn == `FN_0_20_FS27K);
      assign is_41 = (fn == `FN_0_20_FS16K);
      assign is_30 = (fn == `FN_4_20_FS27K);
      assign is_40 = (fn == `FN_4_20_FS16K);
      assign fn_off[c] = (fn == `FN_OFF);
      assign fn_bad[c] = ~(is_31 | is_41 | is_30 | is_40 | fn_off[c]);
      assign fs16k = is_41 | is_40;
      assign live_zero = is_30 | is_40;
      assign code = out_code[c];
      assign hi = fs16k ? `CODE_MAX_FS16K : `CODE_MAX_FS27K;
      // underrange limits, 0 for the 0-20 mA ranges
      assign lo = is_30 ? `CODE_MIN_4_20_FS27K :
                  is_40 ? `CODE_MIN_4_20_FS16K : 16'sh0000;
      assign lim = (code > hi) ? hi : ((code < lo) ? lo : code);
      assign prod = 32'(lim) * (live_zero ? `SPAN_4_20_UA : `SPAN_0_20_UA);
      // the 16384 formats divide by a shift, the 27648 ones need a real divider
      // negative products are biased so the shift truncates toward zero like the divider
      assign quot = fs16k ? ((prod + (prod[31] ? `ROUND_FS16K : 32'sh00000000)) >>> `SHIFT_FS16K) :
                            (prod / `SCALE_FS27K);
      assign ua = quot + (live_zero ? `LIVE_ZERO_UA : 32'sh00000000);
      assign wb_err[c] = wb_sync_reg[c] & wbe_reg[c] & ~fn_off[c] & ~fn_bad[c];
      assign ch_err_byte[c] = {3'h0, wb_err[c], 3'h0, fn_bad[c]};
      always_ff @(posedge core_clk) begin
        if (rst) begin
          cur_reg <= 15'h0000;
          on_reg  <= 1'b0;
        end else begin
          // deactivated or illegal channel drives nothing
          cur_reg <= (fn_off[c] | fn_bad[c]) ? 15'h0000 : ua[14:0];
          on_reg  <= ~(fn_off[c] | fn_bad[c]);
        end
      end
      assign current_ua[c] = cur_reg;
      assign channel_on[c] = on_reg;
    end
  endgenerate

  // diagnostic summary bytes
  wire logic        any_ch_err;
  wire logic        param_err;
  wire logic        ext_err;
  wire byte_t       summary_a;
  wire byte_t       summary_d;
  wire byte_t       group_err;
  wire logic [31:0] diag_vec;
  wire logic        diag_event;

  assign param_err  = |fn_bad;
  assign ext_err    = |wb_err;
  assign group_err  = {6'h00, |ch_err_byte[1], |ch_err_byte[0]};
  assign any_ch_err = |group_err;
  assign summary_a = {param_err, 2'h0, aux_supply_missing, any_ch_err,
                      ext_err, internal_error, module_failure};
  assign summary_d = {3'h0, comm_error, diag_overflow, 3'h0};
  assign diag_vec  = {summary_a, summary_d, ch_err_byte[0], ch_err_byte[1]};
  // capture on a newly raised diagnostic
  assign diag_event = |(diag_vec & ~diag_prev_reg);

  assign channel_error_led = group_err[1:0];
  assign group_error_led   = |summary_a;

  byte_t diag_byte [20];
  assign diag_byte[0]  = summary_a;
  assign diag_byte[1]  = `MODULE_CLASS;
  assign diag_byte[2]  = 8'h00;
  assign diag_byte[3]  = summary_d;
  assign diag_byte[4]  = `CHANNEL_KIND;
  assign diag_byte[5]  = `BITS_PER_CH;
  assign diag_byte[6]  = `CHANNEL_COUNT;
  assign diag_byte[7]  = group_err;
  assign diag_byte[8]  = ch_err_byte[0];
  assign diag_byte[9]  = ch_err_byte[1];
  assign diag_byte[10] = 8'h00;
  assign diag_byte[11] = 8'h00;
  assign diag_byte[12] = 8'h00;
  assign diag_byte[13] = 8'h00;
  assign diag_byte[14] = 8'h00;
  assign diag_byte[15] = 8'h00;
  assign diag_byte[16] = stamp_reg[7:0];
  assign diag_byte[17] = stamp_reg[15:8];
  assign diag_byte[18] = stamp_reg[23:16];
  assign diag_byte[19] = stamp_reg[31:24];

  // address decode, record set numbering
  wire logic        rs_param;
  wire logic        rs_fn;
  wire logic        rs_diag;
  wire logic [1:0]  rs_pidx;
  wire logic [4:0]  rs_dlim;
  // set 00h bytes 0..1, sets 80h/81h function bytes
  assign rs_param = (record_set_number == `SET_PARAM_DIAG) & rec_write & (rec_offset < 5'h02);
  assign rs_fn    = ((record_set_number == `SET_CH0_FN) |
                     (record_set_number == `SET_CH1_FN)) & (rec_offset == 5'h00);
  assign rs_pidx  = rs_fn ? {1'b1, record_set_number[0]} : rec_offset[1:0];
  // set 01h full record, set 00h read gives its head
  assign rs_dlim  = (record_set_number == `SET_DIAG) ? `DIAG_BYTES : `DIAG_HEAD_BYTES;
  assign rs_diag  = ~rec_write & (rec_offset < rs_dlim) &
                    ((record_set_number == `SET_DIAG) | (record_set_number == `SET_PARAM_DIAG));

  // address decode, CANopen indices
  wire logic [15:0] co_rel;
  wire logic        co_param;
  wire logic        co_diag;
  wire logic [4:0]  co_dlim;
  assign co_rel   = object_index - `IX_PARAM_BASE;
  assign co_param = (co_rel < 16'h0004);
  assign co_dlim  = (object_index == `IX_DIAG_ALL) ? `DIAG_BYTES : `DIAG_HEAD_BYTES;
  assign co_diag  = ((object_index == `IX_DIAG_ALL) | (object_index == `IX_DIAG_HEAD)) &
                    (rec_offset < co_dlim);

  // address decode, EtherCAT subindices
  wire logic        ec_param;
  wire logic        ec_dbyte;
  wire logic        ec_stamp;
  wire logic [7:0]  ec_prel;
  wire logic [7:0]  ec_drel;
  assign ec_prel  = object_subindex - `SX_PARAM_FIRST;
  assign ec_drel  = object_subindex - `SX_DIAG_FIRST;
  assign ec_param = (object_index == `IX_PARAM_BASE) &
                    (object_subindex >= `SX_PARAM_FIRST) & (object_subindex <= `SX_PARAM_LAST);
  assign ec_dbyte = (object_index == `IX_ECAT_DIAG) &
                    (object_subindex >= `SX_DIAG_FIRST) & (object_subindex <= `SX_DIAG_LAST);
  assign ec_stamp = (object_index == `IX_ECAT_DIAG) & (object_subindex == `SX_DIAG_STAMP) &
                    (rec_offset < 5'h04);

  // decode merge across the access modes
  logic             p_hit;
  logic [1:0]       p_idx;
  logic             d_hit;
  logic [4:0]       d_idx;
  always_comb begin
    p_hit = 1'b0;
    p_idx = 2'h0;
    d_hit = 1'b0;
    d_idx = 5'h00;
    unique case (rec_mode)
      ACC_RECORD: begin
        p_hit = rs_param | rs_fn;
        p_idx = rs_pidx;
        d_hit = rs_diag;
        d_idx = rec_offset;
      end
      ACC_CANOPEN: begin
        p_hit = co_param;
        p_idx = co_rel[1:0];
        d_hit = co_diag;
        d_idx = rec_offset;
      end
      ACC_ETHERCAT: begin
        p_hit = ec_param;
        p_idx = ec_prel[1:0];
        d_hit = ec_dbyte | ec_stamp;
        d_idx = ec_stamp ? 5'(`DIAG_STAMP_POS + rec_offset) : ec_drel[4:0];
      end
      default: begin
        p_hit = 1'b0;
        p_idx = 2'h0;
        d_hit = 1'b0;
        d_idx = 5'h00;
      end
    endcase
  end

  // diagnostic bytes are read only
  wire logic        acc_ok;
  wire logic        wr_wbe;
  wire logic        wr_fn0;
  wire logic        wr_fn1;
  wire byte_t       p_rd;
  wire byte_t       rd_next;
  assign acc_ok = p_hit | (d_hit & ~rec_write);
  assign wr_wbe = rec_req & rec_write & p_hit & (p_idx == 2'h1);
  assign wr_fn0 = rec_req & rec_write & p_hit & (p_idx == 2'h2);
  assign wr_fn1 = rec_req & rec_write & p_hit & (p_idx == 2'h3);
  // reserved parameter byte reads zero, writes dropped
  assign p_rd = (p_idx == 2'h0) ? `RESERVED_DEFAULT :
                (p_idx == 2'h1) ? wbe_reg :
                (p_idx == 2'h2) ? fn_reg[0] : fn_reg[1];
  assign rd_next = rec_write ? 8'h00 :
                   p_hit ? p_rd :
                   d_hit ? diag_byte[d_idx] : 8'h00;

  // parameter record
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wbe_reg   <= `WBE_DEFAULT;
      fn_reg[0] <= `FN_DEFAULT;
      fn_reg[1] <= `FN_DEFAULT;
    end else begin
      if (wr_wbe)
        wbe_reg <= rec_wdata;
      if (wr_fn0)
        fn_reg[0] <= rec_wdata;
      if (wr_fn1)
        fn_reg[1] <= rec_wdata;
    end
  end

  // record port answer, one cycle after the request
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
    end else begin
      rdata_reg <= rec_req ? rd_next : rdata_reg;
      ack_reg   <= rec_req;
      err_reg   <= rec_req & ~acc_ok;
    end
  end
  assign rec_rdata = rdata_reg;
  assign rec_ack   = ack_reg;
  assign rec_err   = err_reg;

  // wire-break sense arrives from the analog side, asynchronous
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wb_meta_reg <= 2'h0;
      wb_sync_reg <= 2'h0;
    end else begin
      wb_meta_reg <= wire_break_pin;
      wb_sync_reg <= wb_meta_reg;
    end
  end

  // microsecond ticker and diagnostic stamp
  wire logic        tick;
  assign tick = (tick_div_reg == 5'(`TICK_CYCLES - 1));
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tick_div_reg  <= 5'h00;
      ticker_reg    <= 32'h00000000;
      stamp_reg     <= 32'h00000000;
      diag_prev_reg <= 32'h00000000;
    end else begin
      tick_div_reg  <= tick ? 5'h00 : tick_div_reg + 5'h01;
      ticker_reg    <= tick ? ticker_reg + 32'h00000001 : ticker_reg;
      stamp_reg     <= diag_event ? ticker_reg : stamp_reg;
      diag_prev_reg <= diag_vec;
    end
  end

endmodule : current_output_param_diag_bank

// >>> core/aout_consts.svh
// constants of the current-output parameter and diagnostic record bank
// Function
// - parameter record: reserved, wire-break enable, ch0 function, ch1 function; defaults 00,00,31,31
// - function byte FFh switches that output channel off
// - 31h: 0-20 mA, 27648 full scale, clamp to 32511, negatives give 0 mA
// - 41h: 0-20 mA, 16384 full scale, clamp to 20480, negatives give 0 mA
// - 30h: 4-20 mA, 27648 full scale, range -6912 to 32511
// - 40h: 4-20 mA, 16384 full scale, range -4096 to 20480
// - no diagnostic interrupt; errors light channel indicator and enter diagnostic record
// - report parameter errors always, wire-break only when enabled
// - diagnostic record via set 01h/2F01h/5005h; first 4 bytes via set 00h/2F00h
// - diagnostic byte order with fixed 15h, 73h, 08h, 02h and microsecond stamp
// - first summary byte flags failure, internal, external, channel, supply, parameter error
// - module class byte: class 0101b, bit 4 channel info present
// - second summary byte: bit 3 buffer overflow, bit 4 communication error
// - group-error byte: bit 0 group 0, bit 1 group 1
// - channel error byte: bit 0 parameter error, bit 4 wire-break
// - parameters via sets 00h/80h/81h, indices 3100h up, subindices 01h-04h
// - microsecond ticker starts at zero, wraps at 32 bits, captured on diagnostic
`ifndef AOUT_CONSTS_SVH
`define AOUT_CONSTS_SVH
`define RESERVED_DEFAULT 8'h00
`define WBE_DEFAULT      8'h00
`define FN_DEFAULT       8'h31
`define FN_0_20_FS27K       8'h31
`define FN_0_20_FS16K       8'h41
`define FN_4_20_FS27K       8'h30
`define FN_4_20_FS16K       8'h40
`define FN_OFF              8'hFF
`define CODE_MAX_FS27K      16'sh7EFF
`define CODE_MAX_FS16K      16'sh5000
`define CODE_MIN_4_20_FS27K 16'shE500
`define CODE_MIN_4_20_FS16K 16'shF000
`define SCALE_FS27K         32'sh00006C00
`define SHIFT_FS16K         5'h0E
`define ROUND_FS16K         32'sh00003FFF
`define SPAN_0_20_UA     32'sh00004E20
`define SPAN_4_20_UA     32'sh00003E80
`define LIVE_ZERO_UA     32'sh00000FA0
`define SET_PARAM_DIAG   8'h00
`define SET_DIAG         8'h01
`define SET_CH0_FN       8'h80
`define SET_CH1_FN       8'h81
`define IX_PARAM_BASE    16'h3100
`define IX_DIAG_ALL      16'h2F01
`define IX_DIAG_HEAD     16'h2F00
`define IX_ECAT_DIAG     16'h5005
`define SX_PARAM_FIRST   8'h01
`define SX_PARAM_LAST    8'h04
`define SX_DIAG_FIRST    8'h02
`define SX_DIAG_LAST     8'h11
`define SX_DIAG_STAMP    8'h13
`define DIAG_BYTES       5'h14
`define DIAG_HEAD_BYTES  5'h04
`define DIAG_STAMP_POS   5'h10
`define MODULE_CLASS     8'h15
`define CHANNEL_KIND     8'h73
`define BITS_PER_CH      8'h08
`define CHANNEL_COUNT    8'h02
`define US_NS            1000
`define CLK_NS           40
`define TICK_CYCLES      (`US_NS / `CLK_NS)
`endif

// >>> core/aout_pkg.sv
// types shared by the parameter and diagnostic record bank
package aout_pkg;
  typedef enum logic [1:0] {
    ACC_RECORD,
    ACC_CANOPEN,
    ACC_ETHERCAT
  } access_mode_t;
  typedef logic [7:0] byte_t;
endpackage : aout_pkg

// >>> test/output_bank_checker.sv
// assertions on the record port, outputs and indicators of the parameter bank
`timescale 1ns/1ps
module output_bank_checker
  import aout_pkg::*;
(
  input wire logic             core_clk,
  input wire logic             rst,
  input wire logic             rec_req,
  input wire logic             rec_write,
  input wire access_mode_t     rec_mode,
  input wire logic [15:0]      object_index,
  input wire logic [7:0]       rec_wdata,
  input wire logic [7:0]       rec_rdata,
  input wire logic             rec_ack,
  input wire logic             rec_err,
  input wire logic [1:0][15:0] out_code,
  input wire logic             module_failure,
  input wire logic             internal_error,
  input wire logic             aux_supply_missing,
  input wire logic [1:0][14:0] current_ua,
  input wire logic [1:0]       channel_on,
  input wire logic             group_error_led
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_fn0_write(v);
    rec_req && rec_write && rec_mode == ACC_RECORD && object_index == 16'h0080 && rec_wdata == v;
  endsequence
  chk_ack_next: assert property (rec_req |=> rec_ack)
    else $error("request without answer");
  chk_ack_caused: assert property (rec_ack |-> $past(rec_req))
    else $error("answer without request");
  chk_err_paired: assert property (rec_err |-> rec_ack)
    else $error("refusal outside answer");
  chk_diag_write_refused: assert property (rec_req && rec_write && rec_mode == ACC_RECORD
    && object_index == 16'h0001 |=> rec_err) else $error("diag write accepted");
  chk_write_reads_zero: assert property (rec_req && rec_write |=> rec_rdata == 8'h00)
    else $error("write returned data");
  chk_off_channel: assert property (s_fn0_write(8'hFF) |-> ##2 !channel_on[0] && current_ua[0] == 15'h0000)
    else $error("channel not switched off");
  chk_on_default: assert property (s_fn0_write(8'h31) |-> ##2 channel_on[0])
    else $error("channel not switched on");
  chk_zero_code: assert property ($past(out_code[0]) == 16'h0000 |-> current_ua[0] inside {15'h0000, 15'h0FA0})
    else $error("zero code off range start");
  chk_current_cap: assert property (current_ua[0] <= 15'h61A8)
    else $error("current above overrange");
  chk_module_led: assert property (module_failure || internal_error || aux_supply_missing |-> group_error_led)
    else $error("module error not shown");
endmodule : output_bank_checker
bind current_output_param_diag_bank output_bank_checker chk_u (.core_clk, .rst, .rec_req, .rec_write, .rec_mode,
  .object_index, .rec_wdata, .rec_rdata, .rec_ack, .rec_err, .out_code, .module_failure, .internal_error,
  .aux_supply_missing, .current_ua, .channel_on, .group_error_led);

// >>> test/head_station.sv
// head-station model issuing one-byte record accesses over the backplane
`timescale 1ns/1ps
module head_station
  import aout_pkg::*;
(
  input  wire logic       core_clk,
  output logic            rec_req,
  output logic            rec_write,
  output access_mode_t    rec_mode,
  output logic [15:0]     object_index,
  output logic [7:0]      object_subindex,
  output logic [4:0]      rec_offset,
  output logic [7:0]      rec_wdata,
  input  wire logic [7:0] rec_rdata,
  input  wire logic       rec_ack,
  input  wire logic       rec_err
);
  initial begin
    {rec_req, rec_write, object_index, object_subindex, rec_offset, rec_wdata} = '0;
    rec_mode = ACC_RECORD;
  end
  // one byte per access; a refusal or a missing answer is reported to the caller in er
  task automatic acc(input access_mode_t m, input logic [15:0] ix, input logic [7:0] sx, input logic [4:0] off,
                     input logic wr, input logic [7:0] wd, output logic [7:0] rd, output logic er);
    @(posedge core_clk);
    {rec_req, rec_write, rec_mode, object_index} <= {1'b1, wr, m, ix};
    {object_subindex, rec_offset, rec_wdata} <= {sx, off, wd};
    @(posedge core_clk);
    // stale write data is not left on the lines
    rec_req <= 1'b0;
    rec_wdata <= ~wd;
    #1;
    rd = rec_rdata;
    er = rec_err | ~rec_ack;
  endtask : acc
endmodule : head_station

// >>> test/tb.sv
// self-checking bench of the parameter and diagnostic record bank
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; $display("unexpected %0t: %h /= %h", $time, (a), (e)); end end
module tb;
  import aout_pkg::*;
  localparam access_mode_t MR = ACC_RECORD, MC = ACC_CANOPEN, ME = ACC_ETHERCAT;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic rec_req, rec_write, rec_ack, rec_err, er, group_error_led;
  logic module_failure, internal_error, aux_supply_missing, diag_overflow, comm_error;
  access_mode_t rec_mode;
  logic [15:0] object_index;
  logic [15:0] lf = 16'h001C;
  logic [7:0] object_subindex, rec_wdata, rec_rdata, rd, e;
  logic [4:0] rec_offset;
  logic [1:0][15:0] out_code;
  logic [1:0][14:0] current_ua;
  logic [1:0] wire_break_pin, channel_on, channel_error_led;
  logic signed [15:0] code;
  logic [31:0] st;
  int fail_count = 0, tests_run = 0, cyc = 0, t;
  logic [7:0] fns [5] = '{8'h31, 8'h41, 8'h30, 8'h40, 8'hFF};
  logic [15:0] crn [5] = '{16'h0000, 16'h7FFF, 16'h8000, 16'h4000, 16'hFFFF};
  logic [7:0] dg [10] = '{8'h00, 8'h15, 8'h00, 8'h00, 8'h73, 8'h08, 8'h02, 8'h00, 8'h00, 8'h00};
  logic [7:0] pd [4] = '{8'h00, 8'h00, 8'h31, 8'h31};
  current_output_param_diag_bank dut_u (.core_clk, .rst, .rec_req, .rec_write, .rec_mode, .object_index,
    .object_subindex, .rec_offset, .rec_wdata, .rec_rdata, .rec_ack, .rec_err, .out_code, .wire_break_pin,
    .module_failure, .internal_error, .aux_supply_missing, .diag_overflow, .comm_error, .current_ua,
    .channel_on, .channel_error_led, .group_error_led);
  head_station hs_u (.core_clk, .rec_req, .rec_write, .rec_mode, .object_index, .object_subindex, .rec_offset,
    .rec_wdata, .rec_rdata, .rec_ack, .rec_err);
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= rst ? 0 : cyc + 1;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [14:0] exp_ua(input logic [7:0] fn, input logic signed [15:0] c);
    int v;
    v = (fn == 8'h30) ? -6912 : (fn == 8'h40) ? -4096 : 0;
    v = (c < v) ? v : (c > (fn[6] ? 20480 : 32511)) ? (fn[6] ? 20480 : 32511) : c;
    case (fn)
      8'h31: v = v * 20000 / 27648;
      8'h41: v = v * 20000 / 16384;
      8'h30: v = v * 16000 / 27648 + 4000;
      8'h40: v = v * 16000 / 16384 + 4000;
      default: v = 0;
    endcase
    return v[14:0];
  endfunction : exp_ua
  task automatic rdc(input access_mode_t m, input logic [15:0] ix, input logic [7:0] sx, input logic [4:0] o,
                     input logic [8:0] x);
    hs_u.acc(m, ix, sx, o, 1'b0, 8'h00, rd, er);
    `CHK({er, rd}, x)
  endtask : rdc
  task automatic wr(input logic [15:0] ix, input logic [4:0] o, input logic [7:0] d, input logic x);
    hs_u.acc(MR, ix, 8'h00, o, 1'b1, d, rd, er);
    `CHK(er, x)
  endtask : wr
  task automatic get_stamp;
    for (int i = 0; i < 4; i++) begin
      hs_u.acc(ME, 16'h5005, 8'h13, i[4:0], 1'b0, 8'h00, rd, er);
      st[8*i +: 8] = rd;
    end
  endtask : get_stamp
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    final_report();
  end
  initial begin
    out_code = '0;
    wire_break_pin = 2'b00;
    {module_failure, internal_error, aux_supply_missing, diag_overflow, comm_error} = 5'h00;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    get_stamp();
    `CHK(st, 32'h0000_0000)
    for (int i = 0; i < 4; i++) begin
      rdc(MC, 16'h3100 + i[15:0], 8'h00, 5'h00, {1'b0, pd[i]});
      rdc(ME, 16'h3100, 8'h01 + i[7:0], 5'h00, {1'b0, pd[i]});
    end
    rdc(MR, 16'h0081, 8'h00, 5'h00, 9'h031);
    for (int i = 0; i < 16; i++) begin
      e = (i < 10) ? dg[i] : 8'h00;
      rdc(MR, 16'h0001, 8'h00, i[4:0], {1'b0, e});
      rdc(MC, 16'h2F01, 8'h00, i[4:0], {1'b0, e});
      rdc(ME, 16'h5005, 8'h02 + i[7:0], 5'h00, {1'b0, e});
      if (i < 4) rdc(MR, 16'h0000, 8'h00, i[4:0], {1'b0, e});
      if (i < 4) rdc(MC, 16'h2F00, 8'h00, i[4:0], {1'b0, e});
    end
    wr(16'h0001, 5'h01, 8'hA5, 1'b1);
    hs_u.acc(access_mode_t'(2'd3), 16'h3100, 8'h01, 5'h00, 1'b0, 8'h00, rd, er);
    `CHK(er, 1'b1)
    rdc(MR, 16'h0001, 8'h00, 5'h01, 9'h015);
    for (int f = 0; f < 5; f++) begin
      wr(16'h0080, 5'h00, fns[f], 1'b0);
      wr(16'h0081, 5'h00, fns[f], 1'b0);
      for (int k = 0; k < 12; k++) begin
        code = (k < 5) ? crn[k] : {1'b0, lf[14:0]};
        lf = lfsr(lf);
        @(posedge core_clk);
        out_code <= {code >>> 1, code};
        repeat (2) @(posedge core_clk);
        #1;
        `CHK(current_ua[0], exp_ua(fns[f], code))
        `CHK(current_ua[1], exp_ua(fns[f], code >>> 1))
        `CHK(channel_on, {2{fns[f] != 8'hFF}})
      end
    end
    wr(16'h0080, 5'h00, 8'h55, 1'b0);
    repeat (2) @(posedge core_clk);
    `CHK({channel_on[0], channel_error_led[0], group_error_led}, 3'b011)
    rdc(MR, 16'h0001, 8'h00, 5'h00, 9'h088);
    rdc(MR, 16'h0001, 8'h00, 5'h07, 9'h001);
    rdc(MR, 16'h0001, 8'h00, 5'h08, 9'h001);
    wr(16'h0080, 5'h00, 8'h31, 1'b0);
    wr(16'h0081, 5'h00, 8'h31, 1'b0);
    wire_break_pin <= 2'b10;
    repeat (4) @(posedge core_clk);
    rdc(MR, 16'h0001, 8'h00, 5'h09, 9'h000);
    wr(16'h0000, 5'h01, 8'h02, 1'b0);
    rdc(MR, 16'h0001, 8'h00, 5'h09, 9'h010);
    rdc(MR, 16'h0001, 8'h00, 5'h07, 9'h002);
    rdc(MR, 16'h0000, 8'h00, 5'h00, 9'h00C);
    `CHK(channel_error_led, 2'b10)
    wire_break_pin <= 2'b00;
    repeat (4) @(posedge core_clk);
    {module_failure, internal_error, aux_supply_missing, diag_overflow, comm_error} <= 5'h1F;
    t = cyc;
    repeat (2) @(posedge core_clk);
    rdc(MR, 16'h0000, 8'h00, 5'h00, 9'h013);
    rdc(MR, 16'h0000, 8'h00, 5'h03, 9'h018);
    get_stamp();
    `CHK(st >= t / 25 - 1 && st <= t / 25 + 1, 1'b1)
    final_report();
  end
endmodule : tb
